//--- rtl/fwsr_host.sv
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
// host side flash status poller with an ahb-lite register port
module fwsr_host
    import fwsr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [16:0] flash_addr,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic      [7:0]  flash_dq_o,
    output logic             flash_dq_oe,
    input  wire logic [7:0]  flash_dq_i
);

    logic        wr_pend_q;     // write data phase pending
    logic [7:0]  wr_ofs_q;      // offset of pending write
    logic [16:0] addr_q;        // flash address register
    logic [7:0]  wdata_q;       // write data / expected byte
    fwsr_op_e    op_q;          // selected operation
    logic        sel_q;         // toggle bit select, 1 = sector toggle
    logic        go_q;          // one cycle start pulse
    fwsr_state_e state_q;       // bus cycle state
    fwsr_phase_e phase_q;       // polling phase
    logic [3:0]  cnt_q;         // strobe length counter
    logic [7:0]  rdata_q;       // last byte read
    logic        prev_q;        // toggle bit of previous read
    logic        done_q;        // operation finished
    logic        fail_q;        // operation failed, reset issued
    logic [7:0]  dq_sync;       // synchronised data bus
    logic        busy;          // an operation is running
    logic        last;          // counter at its last cycle

    // pick the toggle bit under watch
    function automatic logic tog_of(input logic [7:0] b, input logic s);
        return s ? b[FWSR_SECTOR_BIT] : b[FWSR_ACT_BIT];
    endfunction

    // register read mux
    function automatic logic [31:0] reg_read(input logic [7:0] ofs);
        logic [31:0] r;
        r = '0;
        unique case (ofs)
            FWSR_CTRL_OFS: begin
                r[FWSR_CTRL_OP_POS +: 2] = op_q;
                r[FWSR_CTRL_SEL_POS]     = sel_q;
            end
            FWSR_ADDR_OFS:  r[16:0] = addr_q;
            FWSR_WDATA_OFS: r[7:0]  = wdata_q;
            FWSR_STATUS_OFS: begin
                r[FWSR_ST_BUSY_POS]       = busy;
                r[FWSR_ST_DONE_POS]       = done_q;
                r[FWSR_ST_FAIL_POS]       = fail_q;
                r[FWSR_ST_RDATA_POS +: 8] = rdata_q;
            end
            default: r = '0;
        endcase
        return r;
    endfunction

    assign busy       = (state_q != FWSR_S_IDLE);
    assign last       = (cnt_q == 4'h1);
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign flash_addr = addr_q;

    // data bus pins come from the flash's own timing
    fwsr_sync #(
        .W (8)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (flash_dq_i),
        .dout    (dq_sync)
    );

    // ahb address phase capture, read data registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_ofs_q  <= 8'h00;
            hrdata    <= 32'h0000_0000;
        end else if (hready) begin
            wr_pend_q <= hsel & htrans[1] & hwrite;
            wr_ofs_q  <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                hrdata <= reg_read(haddr[7:0]);
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // software registers, ignored while an operation runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q  <= FWSR_ADDR_RST;
            wdata_q <= FWSR_WDATA_RST;
            op_q    <= FWSR_OP_WRITE;
            sel_q   <= 1'b0;
            go_q    <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (wr_pend_q && !busy && !go_q) begin
                unique case (wr_ofs_q)
                    FWSR_CTRL_OFS: begin
                        op_q  <= fwsr_op_e'(hwdata[FWSR_CTRL_OP_POS +: 2]);
                        sel_q <= hwdata[FWSR_CTRL_SEL_POS];
                        go_q  <= hwdata[FWSR_CTRL_GO_POS];
                    end
                    FWSR_ADDR_OFS:  addr_q  <= hwdata[16:0];
                    FWSR_WDATA_OFS: wdata_q <= hwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // flash bus cycles and polling decisions
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q     <= FWSR_S_IDLE;
            phase_q     <= FWSR_PH_FIRST;
            cnt_q       <= 4'h0;
            rdata_q     <= 8'h00;
            prev_q      <= 1'b0;
            done_q      <= 1'b0;
            fail_q      <= 1'b0;
            flash_ce_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
            flash_we_n  <= 1'b1;
            flash_dq_o  <= 8'h00;
            flash_dq_oe <= 1'b0;
        end else begin
            unique case (state_q)
                FWSR_S_IDLE: begin
                    if (go_q) begin
                        done_q  <= 1'b0;
                        fail_q  <= 1'b0;
                        // every toggle start re-runs the double read
                        phase_q <= FWSR_PH_FIRST;
                        if (op_q == FWSR_OP_WRITE) begin
                            state_q     <= FWSR_S_WR;
                            cnt_q       <= FWSR_WE_CYC;
                            flash_dq_o  <= wdata_q;
                            flash_dq_oe <= 1'b1;
                            flash_ce_n  <= 1'b0;
                            flash_we_n  <= 1'b0;
                        end else begin
                            state_q    <= FWSR_S_RD;
                            cnt_q      <= FWSR_RD_CYC;
                            flash_ce_n <= 1'b0;
                            flash_oe_n <= 1'b0;
                        end
                    end
                end
                FWSR_S_WR: begin
                    if (last) begin
                        flash_we_n <= 1'b1;
                        flash_ce_n <= 1'b1;
                        state_q    <= FWSR_S_WR_REC;
                        cnt_q      <= FWSR_REC_CYC;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                FWSR_S_WR_REC: begin
                    if (last) begin
                        flash_dq_oe <= 1'b0;
                        state_q     <= FWSR_S_IDLE;
                        // a reset write after failure leaves done low
                        done_q      <= (phase_q != FWSR_PH_RESET);
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                FWSR_S_RD: begin
                    if (last) begin
                        rdata_q    <= dq_sync;
                        flash_ce_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        state_q    <= FWSR_S_RD_REC;
                        cnt_q      <= FWSR_REC_CYC;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                FWSR_S_RD_REC: begin
                    if (!last) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (op_q == FWSR_OP_READ || phase_q == FWSR_PH_FINAL) begin
                        // data taken from the read after completion
                        done_q  <= 1'b1;
                        state_q <= FWSR_S_IDLE;
                    end else if (op_q == FWSR_OP_POLL) begin
                        state_q    <= FWSR_S_RD;
                        cnt_q      <= FWSR_RD_CYC;
                        flash_ce_n <= 1'b0;
                        flash_oe_n <= 1'b0;
                        if (rdata_q[FWSR_POLL_BIT] == wdata_q[FWSR_POLL_BIT]) begin
                            // true bit seen, one more read
                            phase_q <= FWSR_PH_FINAL;
                        end else if (phase_q == FWSR_PH_RECHECK) begin
                            phase_q     <= FWSR_PH_RESET;
                            flash_ce_n  <= 1'b0;
                            fail_q      <= 1'b1;
                            state_q     <= FWSR_S_WR;
                            cnt_q       <= FWSR_WE_CYC;
                            flash_dq_o  <= FWSR_RESET_CMD;
                            flash_dq_oe <= 1'b1;
                            flash_oe_n  <= 1'b1;
                            flash_we_n  <= 1'b0;
                        end else if (rdata_q[FWSR_LIMIT_BIT]) begin
                            phase_q <= FWSR_PH_RECHECK;
                        end else begin
                            phase_q <= FWSR_PH_RUN;
                        end
                    end else begin
                        state_q    <= FWSR_S_RD;
                        cnt_q      <= FWSR_RD_CYC;
                        flash_ce_n <= 1'b0;
                        flash_oe_n <= 1'b0;
                        prev_q     <= tog_of(rdata_q, sel_q);
                        if (phase_q == FWSR_PH_FIRST) begin
                            phase_q <= FWSR_PH_RUN;
                        end else if (tog_of(rdata_q, sel_q) == prev_q) begin
                            // steady bit, array data next read
                            phase_q <= FWSR_PH_FINAL;
                        end else if (phase_q == FWSR_PH_RECHECK) begin
                            phase_q     <= FWSR_PH_RESET;
                            flash_ce_n  <= 1'b0;
                            fail_q      <= 1'b1;
                            state_q     <= FWSR_S_WR;
                            cnt_q       <= FWSR_WE_CYC;
                            flash_dq_o  <= FWSR_RESET_CMD;
                            flash_dq_oe <= 1'b1;
                            flash_oe_n  <= 1'b1;
                            flash_we_n  <= 1'b0;
                        end else if (rdata_q[FWSR_LIMIT_BIT]) begin
                            phase_q <= FWSR_PH_RECHECK;
                        end
                    end
                end
            endcase
        end
    end

endmodule

//--- rtl/fwsr_pkg.sv
// Summary of operation
// - host polls at the programmed address
// - host polls erase inside chosen sector
// - host takes data only from later read
// - host double reads, compares toggle bit
// - toggling with limit flag: recheck, reset
// - no limit flag: host reads on, each read compared with the one before
package fwsr_pkg;

    // register byte offsets on the ahb-lite port
    localparam logic [7:0] FWSR_CTRL_OFS   = 8'h00;
    localparam logic [7:0] FWSR_ADDR_OFS   = 8'h04;
    localparam logic [7:0] FWSR_WDATA_OFS  = 8'h08;
    localparam logic [7:0] FWSR_STATUS_OFS = 8'h0c;

    // ctrl fields
    localparam int FWSR_CTRL_GO_POS  = 0;
    localparam int FWSR_CTRL_OP_POS  = 1;
    localparam int FWSR_CTRL_SEL_POS = 3;

    // status fields
    localparam int FWSR_ST_BUSY_POS  = 0;
    localparam int FWSR_ST_DONE_POS  = 1;
    localparam int FWSR_ST_FAIL_POS  = 2;
    localparam int FWSR_ST_RDATA_POS = 8;

    // status byte bit positions of the flash
    localparam int FWSR_POLL_BIT   = 7;
    localparam int FWSR_ACT_BIT    = 6;
    localparam int FWSR_LIMIT_BIT  = 5;
    localparam int FWSR_SECTOR_BIT = 2;

    // reset values
    localparam logic [16:0] FWSR_ADDR_RST  = 17'h0_0000;
    localparam logic [7:0]  FWSR_WDATA_RST = 8'h00;
    localparam logic [7:0]  FWSR_RESET_CMD = 8'hf0;

    // bus timing, in ns, and the cycle counts at 10 mhz
    localparam int FWSR_CLK_NS    = 100;
    localparam int FWSR_WE_NS     = 200;
    localparam int FWSR_RD_NS     = 500;
    localparam int FWSR_REC_NS    = 100;
    localparam logic [3:0] FWSR_WE_CYC  = 4'((FWSR_WE_NS + FWSR_CLK_NS - 1) / FWSR_CLK_NS);
    localparam logic [3:0] FWSR_RD_CYC  = 4'((FWSR_RD_NS + FWSR_CLK_NS - 1) / FWSR_CLK_NS);
    localparam logic [3:0] FWSR_REC_CYC = 4'((FWSR_REC_NS + FWSR_CLK_NS - 1) / FWSR_CLK_NS);

    // operations started through ctrl
    typedef enum logic [1:0] {
        FWSR_OP_WRITE,
        FWSR_OP_READ,
        FWSR_OP_POLL,
        FWSR_OP_TOGGLE
    } fwsr_op_e;

    // bus cycle states
    typedef enum logic [2:0] {
        FWSR_S_IDLE,
        FWSR_S_WR,
        FWSR_S_WR_REC,
        FWSR_S_RD,
        FWSR_S_RD_REC
    } fwsr_state_e;

    // polling phases
    typedef enum logic [2:0] {
        FWSR_PH_FIRST,
        FWSR_PH_RUN,
        FWSR_PH_RECHECK,
        FWSR_PH_FINAL,
        FWSR_PH_RESET
    } fwsr_phase_e;

endpackage

//--- rtl/fwsr_sync.sv
`timescale 1ns/1ps
// three stage pin synchroniser, output moves once stages two and three agree
module fwsr_sync
    import fwsr_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] s1_q;     // first stage, read only by s2
    logic [W-1:0] s2_q;     // second stage
    logic [W-1:0] s3_q;     // third stage

    // shift chain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a change only when settled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dout <= '0;
        end else if (s2_q == s3_q) begin
            dout <= s3_q;
        end
    end

endmodule

//--- tb/fwsr_flash_model.sv
`timescale 1ns/1ps
// behavioural flash: status bytes while an internal operation runs
module fwsr_flash_model #(
    parameter int PROG_NS = 3000,   // program time
    parameter int PROT_NS = 1000,   // activity shown for a protected program
    parameter int NONE_NS = 100000  // activity shown when all chosen sectors are protected
) (
    input  wire logic [16:0] flash_addr,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    input  wire logic [7:0]  flash_dq_o,
    input  wire logic        flash_dq_oe,
    output logic      [7:0]  dq_drv
);
    logic [7:0]  mem [0:255]; // array window on the low address bits
    logic [7:0]  last_q;      // byte of the current read
    logic [1:0]  op_q;        // 0 array, 1 program, 2 erase, 3 erase suspended
    logic [7:0]  pd_q;        // byte being programmed
    logic [16:0] pa_q;        // program or erase address
    logic        prot_q;      // target protected, nothing changes
    logic        stuck_q;     // pulse limit exceeded, set by the bench
    logic        t6_q;        // activity toggle
    logic        t2_q;        // sector toggle
    logic [7:0]  prot_map;    // protected sectors, set by the bench
    realtime     end_t;       // when the operation ends
    wire         rd_n = flash_ce_n | flash_oe_n;
    wire         wr_n = flash_ce_n | flash_we_n;
    wire         in_sec = flash_addr[16:14] == pa_q[16:14];

    // released bus shows the inverse of the last byte, no pull
    assign dq_drv = rd_n ? ~last_q : last_q;

    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        {last_q, op_q, stuck_q, t6_q, t2_q, prot_map} = '0;
    end

    // protected targets show activity for a fixed time
    task automatic start(input logic [1:0] op, input logic [16:0] a, input logic [7:0] d,
                         input int ns);
        op_q = op;
        pa_q = a;
        pd_q = d;
        prot_q = prot_map[a[16:14]];
        end_t = $realtime + (prot_q ? ((op == 2'd1) ? PROT_NS : NONE_NS) : ns);
    endtask

    // status from the final strobe; reset command clears the limit
    always @(posedge wr_n) begin
        if (flash_dq_oe === 1'b1 && flash_dq_o == 8'hf0) begin
            op_q = 2'd0;
            stuck_q = 1'b0;
        end else if (flash_dq_oe === 1'b1 && op_q == 2'd0) begin
            start(2'd1, flash_addr, flash_dq_o, PROG_NS);
        end
    end

    // byte chosen as each read begins
    always @(negedge rd_n) begin
        if ((op_q == 2'd1 || op_q == 2'd2) && !stuck_q && $realtime >= end_t) begin
            if (!prot_q && op_q == 2'd1) mem[pa_q[7:0]] = pd_q;
            op_q = 2'd0;
        end
        case (op_q)
            2'd1: last_q = {~pd_q[7], t6_q, stuck_q, 5'b0_0000};
            2'd2: last_q = {1'b0, t6_q, stuck_q, 2'b01, in_sec & t2_q, 2'b00};
            2'd3: last_q = in_sec ? {1'b1, t6_q, 3'b000, t2_q, 2'b00} : mem[flash_addr[7:0]];
            default: last_q = mem[flash_addr[7:0]];
        endcase
    end

    // toggles invert once per completed read: activity in program or erase, sector in the erase sector
    always @(posedge rd_n) begin
        if (op_q == 2'd1 || op_q == 2'd2) t6_q = ~t6_q;
        if (op_q[1] && in_sec) t2_q = ~t2_q;
    end
endmodule

//--- tb/fwsr_host_props.sv
`timescale 1ns/1ps
// pin level checks on the poller's flash bus cycles
module fwsr_host_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [16:0] flash_addr,
    input wire logic        flash_ce_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic [7:0]  flash_dq_o,
    input wire logic        flash_dq_oe
);
    // one clock domain for every property
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    addr_hold_a: assert property (
        !flash_oe_n && !$fell(flash_oe_n) |-> $stable(flash_addr))
        else $error("flash address moved inside a read cycle");
    poll_addr_a: assert property (
        $rose(flash_oe_n) ##1 $fell(flash_oe_n) |-> $stable(flash_addr))
        else $error("chained poll reads used another address");
    read_len_a: assert property (
        $fell(flash_oe_n) |-> !flash_oe_n [*5] ##1 flash_oe_n)
        else $error("read cycle not five cycles long");
    read_frame_a: assert property (
        !flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
        else $error("read cycle framed wrongly");
    write_frame_a: assert property (
        !flash_we_n |-> flash_dq_oe && !flash_ce_n && flash_oe_n)
        else $error("write cycle framed wrongly");
    write_len_a: assert property (
        $fell(flash_we_n) |-> !flash_we_n [*2] ##1 (flash_we_n && flash_dq_oe) ##1 !flash_dq_oe)
        else $error("write strobe or recovery length wrong");

    // main scenarios seen
    cover property ($fell(flash_oe_n));
    cover property ($rose(flash_oe_n) ##1 $fell(flash_oe_n));
    cover property ($fell(flash_we_n) ##1 flash_dq_o == 8'hf0);
endmodule

bind fwsr_host fwsr_host_props u_fwsr_host_props (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .flash_addr  (flash_addr),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe)
);

//--- tb/fwsr_host_tb.sv
`timescale 1ns/1ps
// bench for the flash status poller, driven through its register port
module fwsr_host_tb
    import fwsr_pkg::*;
;
    logic        hclk, hresetn, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, st, st2;
    logic [1:0]  htrans;
    logic [16:0] flash_addr;
    logic        flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
    logic [7:0]  flash_dq_o, flash_dq_i, dq_drv;
    int          bad_count, n_compared, cyc;
    realtime     t0;

    // data bus: host when enabled, else the device
    assign flash_dq_i = flash_dq_oe ? flash_dq_o : dq_drv;

    fwsr_host u_fwsr_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flash_addr(flash_addr),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i));
    fwsr_flash_model u_flash (.flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe), .dq_drv(dq_drv));

    // 10 mhz clock
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // waits for hready high at a rising edge
    task automatic rdy();
        @(posedge hclk);
        while (hready_ok() !== 1'b1) @(posedge hclk);
    endtask
    function automatic logic hready_ok();
        return hreadyout;
    endfunction

    task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] q);
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        rdy();
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
        q = hrdata;
    endtask

    // loads address and byte, starts ctrl, reads status until finished
    task automatic op(input logic [16:0] a, input logic [7:0] d, input logic [31:0] c);
        int n;
        ahb(FWSR_ADDR_OFS, 1'b1, {15'h0000, a}, st);
        ahb(FWSR_WDATA_OFS, 1'b1, {24'h00_0000, d}, st);
        ahb(FWSR_CTRL_OFS, 1'b1, c, st);
        repeat (2) @(posedge hclk);
        n = 0;
        do begin
            ahb(FWSR_STATUS_OFS, 1'b0, 32'h0000_0000, st);
            n++;
        end while (!(st[0] === 1'b0 && (st[1] | st[2]) === 1'b1) && n < 5000);
    endtask

    task automatic since(input real ns);
        chk("elapsed", 32'h1, {31'h0, ($realtime - t0) >= ns});
    endtask

    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata, bad_count, n_compared, cyc} = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(FWSR_STATUS_OFS, 1'b0, 32'h0, st);
        chk("status", 32'h0000_0000, st);
        chk("response", 32'h0, {31'h0, hresp});
        ahb(FWSR_ADDR_OFS, 1'b1, 32'h0001_2345, st);
        ahb(FWSR_ADDR_OFS, 1'b0, 32'h0, st);
        chk("addr", 32'h0001_2345, st);
        ahb(8'h10, 1'b0, 32'h0, st);
        chk("unmapped", 32'h0000_0000, st);
        $display("test registers done");
        op(17'h0_0012, 8'ha5, 32'h0000_0001);
        op(17'h0_0012, 8'ha5, 32'h0000_0007);
        chk("program toggle", 32'h0000_a502, st);
        op(17'h0_0013, 8'h3c, 32'h0000_0001);
        op(17'h0_0013, 8'h3c, 32'h0000_0005);
        chk("program poll", 32'h0000_3c02, st);
        $display("test program done");
        u_flash.prot_map = 8'h05;
        t0 = $realtime;
        op(17'h0_0020, 8'h77, 32'h0000_0001);
        op(17'h0_0020, 8'h77, 32'h0000_0007);
        chk("protected program", 32'h0000_ff02, st);
        since(1000.0);
        t0 = $realtime;
        u_flash.start(2'd2, 17'h0_8000, 8'h00, 20000);
        op(17'h0_8000, 8'hff, 32'h0000_0007);
        chk("protected erase", 32'h0000_ff02, st);
        since(100000.0);
        $display("test protection done");
        t0 = $realtime;
        u_flash.start(2'd2, 17'h0_4005, 8'h00, 20000);
        op(17'h0_4005, 8'hff, 32'h0000_0005);
        chk("erase poll", 32'h0000_ff02, st);
        since(20000.0);
        t0 = $realtime;
        u_flash.start(2'd2, 17'h0_4005, 8'h00, 20000);
        op(17'h0_4005, 8'hff, 32'h0000_000f);
        chk("erase sector toggle", 32'h0000_ff02, st);
        since(20000.0);
        u_flash.op_q = 2'd3;
        op(17'h0_4005, 8'hff, 32'h0000_0003);
        st2 = st;
        op(17'h0_4005, 8'hff, 32'h0000_0003);
        chk("suspend poll bit", 32'h1, {31'h0, st[15]});
        chk("suspend activity", 32'h0, {31'h0, st[14] ^ st2[14]});
        chk("suspend sector", 32'h1, {31'h0, st[10] ^ st2[10]});
        u_flash.op_q = 2'd0;
        $display("test erase done");
        op(17'h0_0030, 8'h00, 32'h0000_0001);
        u_flash.stuck_q = 1'b1;
        op(17'h0_0030, 8'h00, 32'h0000_0007);
        chk("limit status", 32'h0000_0004, {24'h0, st[7:0]});
        chk("device reset", 32'h0, {30'h0, u_flash.op_q});
        op(17'h0_0031, 8'h00, 32'h0000_0001);
        u_flash.stuck_q = 1'b1;
        op(17'h0_0031, 8'h00, 32'h0000_0005);
        chk("poll limit status", 32'h0000_0004, {24'h0, st[7:0]});
        chk("poll device reset", 32'h0, {30'h0, u_flash.op_q});
        $display("test limit done");
        give_verdict();
    end
endmodule
